// ### hw/sbsr_cfg.svh
/*
  Constants for the status byte and service request block: bit positions
  inside the status byte, the reset value of the request mask and the
  groups of bits that take part in request generation.
  Assumes it is included by bare name from the block's own sources.
*/
`ifndef SBSR_CFG_SVH
`define SBSR_CFG_SVH

// Bit positions inside the eight-bit status byte.
`define SBSR_BIT_ERR   2
`define SBSR_BIT_QUES  3
`define SBSR_BIT_MAV   4
`define SBSR_BIT_ESB   5
`define SBSR_BIT_MSS   6
`define SBSR_BIT_OPER  7

// Reset value of the service request enable mask.
`define SBSR_MASK_RST  8'h00

// Bits that may raise a request: 2, 3, 4, 5 and 7; bit 6 and bits 0 and 1 never.
`define SBSR_REQ_BITS  8'hbc

// Bits that always read as zero in the status byte.
`define SBSR_UNUSED_BITS 8'h03

`endif

// ### hw/sbsr_pkg.sv
/*
  Types shared by the status byte and service request block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sbsr_pkg;

  // One status byte or mask byte.
  typedef logic [7:0] sbsr_byte_t;

  // Commands that the remote controller may issue to this block.
  typedef enum logic [1:0] {
    SBSR_CMD_STB_QUERY,
    SBSR_CMD_SERIAL_POLL,
    SBSR_CMD_MASK_WRITE,
    SBSR_CMD_MASK_QUERY
  } sbsr_cmd_e;

endpackage

// ### hw/sbsr_sum_if.sv
/*
  Carrier between the summary stage and the request stage: the registered
  condition byte and the one-cycle event byte.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface sbsr_sum_if;
  import sbsr_pkg::*;

  sbsr_byte_t cond;  // Registered status byte conditions, bit 6 always zero.
  sbsr_byte_t evt;   // One-cycle request events per status byte bit.

  // The summary stage produces both bytes.
  modport prod (output cond, output evt);
  // The request stage only reads them.
  modport cons (input cond, input evt);
endinterface

`default_nettype wire

// ### hw/sbsr_summary.sv
/*
  Summary stage: folds the lower status registers into the status byte
  conditions and detects the events that may raise a service request.
  Assumes all inputs are synchronous to core_clk_in and that the error
  queue reports each new entry with a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbsr_cfg.svh"

module sbsr_summary #(
  parameter int QUES_W = 16,
  parameter int OPER_W = 16,
  parameter int ESR_W  = 8
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              err_entry_in,
  input  wire logic              err_nonempty_in,
  input  wire logic [QUES_W-1:0] ques_event_in,
  input  wire logic [QUES_W-1:0] ques_enable_in,
  input  wire logic              msg_avail_in,
  input  wire logic [ESR_W-1:0]  esr_in,
  input  wire logic [ESR_W-1:0]  ese_in,
  input  wire logic [OPER_W-1:0] oper_event_in,
  input  wire logic [OPER_W-1:0] oper_enable_in,
  sbsr_sum_if.prod               sum
);
  import sbsr_pkg::*;

  sbsr_byte_t       cond_r;    // Registered conditions.
  sbsr_byte_t       cond_nxt;  // Conditions formed from the inputs.
  sbsr_byte_t       evt_r;     // Registered events.
  sbsr_byte_t       evt_nxt;   // Events formed this cycle.
  logic [ESR_W-1:0] esr_r;     // Last event status bits, for rise detection.

  // Bits 3, 5 and 7 are the OR of their lower register anded with its enable; bits 2 and 4 follow their inputs.
  always_comb begin
    cond_nxt = 8'h00;
    cond_nxt[`SBSR_BIT_ERR]  = err_nonempty_in | err_entry_in;   // [RULE5]
    cond_nxt[`SBSR_BIT_QUES] = |(ques_event_in & ques_enable_in); // [RULE7]
    cond_nxt[`SBSR_BIT_MAV]  = msg_avail_in;                      // [RULE8]
    cond_nxt[`SBSR_BIT_ESB]  = |(esr_in & ese_in);                // [RULE9]
    cond_nxt[`SBSR_BIT_OPER] = |(oper_event_in & oper_enable_in); // [RULE11]
  end

  // Events are rising conditions; the error bit also fires on every new
  // entry, since a queue that stays non-empty would otherwise raise only once.
  always_comb begin
    evt_nxt = cond_nxt & ~cond_r;                                  // [RULE3]
    evt_nxt[`SBSR_BIT_ERR] = err_entry_in | (cond_nxt[`SBSR_BIT_ERR]
                             & ~cond_r[`SBSR_BIT_ERR]);            // [RULE6]
    evt_nxt[`SBSR_BIT_ESB] = |(esr_in & ~esr_r & ese_in)
                             | (cond_nxt[`SBSR_BIT_ESB]
                             & ~cond_r[`SBSR_BIT_ESB]);            // [RULE12]
    evt_nxt = evt_nxt & `SBSR_REQ_BITS;                            // [RULE13]
  end

  // Condition register and its history.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cond_r <= 8'h00;
      esr_r  <= '0;
    end else begin
      cond_r <= cond_nxt;
      esr_r  <= esr_in;
    end
  end

  // Event register, one cycle wide per cause.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      evt_r <= 8'h00;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign sum.cond = cond_r;
  assign sum.evt  = evt_r;

  // Every error entry yields its own event one cycle later.
  a_err_each_entry: assert property (@(posedge core_clk_in) disable iff (rst_in)
    err_entry_in |=> sum.evt[`SBSR_BIT_ERR]) // [RULE6]
    else $error("error entry gave no event");

  // A non-empty queue shows in bit 2 one cycle later.
  a_err_bit_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
    err_nonempty_in |=> sum.cond[`SBSR_BIT_ERR]) // [RULE5]
    else $error("error bit not set");

  // Questionable summary follows its enabled events.
  a_ques_summary: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 sum.cond[`SBSR_BIT_QUES] == $past(|(ques_event_in & ques_enable_in))) // [RULE7]
    else $error("questionable summary wrong");

  // Message available follows the output queue.
  a_mav_follows: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 sum.cond[`SBSR_BIT_MAV] == $past(msg_avail_in)) // [RULE8]
    else $error("message available bit wrong");

  // Event status summary follows enabled event status bits.
  a_esb_summary: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 sum.cond[`SBSR_BIT_ESB] == $past(|(esr_in & ese_in))) // [RULE9]
    else $error("event status summary wrong");

  // An enabled event status bit rising gives an event.
  a_esb_rise_evt: assert property (@(posedge core_clk_in) disable iff (rst_in)
    |(esr_in & ~esr_r & ese_in) |=> sum.evt[`SBSR_BIT_ESB]) // [RULE12]
    else $error("event status rise lost");

  // Operation summary follows its enabled events.
  a_oper_summary: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 sum.cond[`SBSR_BIT_OPER] == $past(|(oper_event_in & oper_enable_in))) // [RULE11]
    else $error("operation summary wrong");
endmodule

`default_nettype wire

// ### hw/sbsr_top.sv
/*
  Status byte and service request block. Holds the service request mask,
  forms the main summary bit, keeps the request pending until a serial
  poll and answers the controller's status and mask commands.
  Assumes a command decoder in front that presents one command per
  cycle on cmd_valid_in, and a bus driver behind srq_out and the answer.
  A status query never clears a pending request; only a serial poll does,
  so a controller that only queries keeps the line up. That is intended:
  a query cannot hide a request from the poll that follows it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbsr_cfg.svh"

// Behaviour
// RULE1 - Status byte readable by query or poll.
// RULE2 - Mask per bit; mask bit 6 ignored.
// RULE3 - Enabled bit rising raises a service request.
// RULE4 - Mask written by command, read back unchanged.
// RULE5 - Bit 2 set on error queue entry.
// RULE6 - Each error entry raises its own request.
// RULE7 - Bit 3: enabled questionable event summary.
// RULE8 - Bit 4: output queue holds a message.
// RULE9 - Bit 5: enabled event status summary.
// RULE10 - Bit 6: any other enabled bit set. The serial poll answer carries the pending request in bit 6 instead.
// RULE11 - Bit 7: enabled operation event summary.
// RULE12 - Enabled event status bit rising sets summary.
// RULE13 - Bits 0 and 1 read zero, never request.
module sbsr_top #(
  parameter int QUES_W = 16,
  parameter int OPER_W = 16,
  parameter int ESR_W  = 8
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  input  wire logic                cmd_valid_in,
  input  wire sbsr_pkg::sbsr_cmd_e cmd_code_in,
  input  wire sbsr_pkg::sbsr_byte_t cmd_data_in,
  output var  logic                resp_valid_out,
  output var  sbsr_pkg::sbsr_byte_t resp_data_out,
  output var  logic                srq_out,
  input  wire logic                err_entry_in,
  input  wire logic                err_nonempty_in,
  input  wire logic [QUES_W-1:0]   ques_event_in,
  input  wire logic [QUES_W-1:0]   ques_enable_in,
  input  wire logic                msg_avail_in,
  input  wire logic [ESR_W-1:0]    esr_in,
  input  wire logic [ESR_W-1:0]    ese_in,
  input  wire logic [OPER_W-1:0]   oper_event_in,
  input  wire logic [OPER_W-1:0]   oper_enable_in
);
  import sbsr_pkg::*;

  sbsr_sum_if sum ();            // Conditions and events from the summary stage.

  sbsr_byte_t mask_r;            // Service request enable mask as written.
  sbsr_byte_t req_mask;          // Mask with bit 6 and the unused bits removed.
  logic       mss;               // Main summary: some enabled bit is set.
  sbsr_byte_t stb_view;          // Status byte as the query returns it.
  sbsr_byte_t poll_view;         // Status byte as the serial poll returns it.
  logic       req_evt;           // A request event this cycle.
  logic       srq_pend_r;        // Request pending until a serial poll.
  logic       srq_pend_nxt;      // Next value of the pending request.
  logic       do_poll;           // Serial poll taken this cycle.
  logic       do_mask_wr;        // Mask write taken this cycle.
  logic       resp_valid_nxt;    // Answer due next cycle.
  sbsr_byte_t resp_data_nxt;     // Answer data due next cycle.

  // The summary stage registers the lower status inputs.
  // Every condition thus lags its input by one edge, which the
  // request path counts on when it times the line.
  sbsr_summary #(
    .QUES_W (QUES_W),
    .OPER_W (OPER_W),
    .ESR_W  (ESR_W)
  ) sbsr_summary_inst (
    .core_clk_in     (core_clk_in),
    .rst_in          (rst_in),
    .err_entry_in    (err_entry_in),
    .err_nonempty_in (err_nonempty_in),
    .ques_event_in   (ques_event_in),
    .ques_enable_in  (ques_enable_in),
    .msg_avail_in    (msg_avail_in),
    .esr_in          (esr_in),
    .ese_in          (ese_in),
    .oper_event_in   (oper_event_in),
    .oper_enable_in  (oper_enable_in),
    .sum             (sum.prod)
  );

  // Command strobes decoded once so each process reads the same decision.
  assign do_poll    = cmd_valid_in && (cmd_code_in == SBSR_CMD_SERIAL_POLL);
  assign do_mask_wr = cmd_valid_in && (cmd_code_in == SBSR_CMD_MASK_WRITE);

  // Bit 6 of the mask is stored for read-back but never used here; bits 0
  // and 1 are dropped too since their conditions never exist.
  assign req_mask = mask_r & `SBSR_REQ_BITS; // [RULE2] [RULE13]

  // The main summary is a level, recomputed every cycle from the conditions.
  assign mss = |(sum.cond & req_mask); // [RULE10]

  // Query view carries the main summary in bit 6; the conditions already
  // hold zero in bits 0, 1 and 6.
  always_comb begin
    stb_view = sum.cond & ~`SBSR_UNUSED_BITS; // [RULE13]
    stb_view[`SBSR_BIT_MSS] = mss;            // [RULE10]
  end

  // The poll view shows the pending request in bit 6 instead, so a
  // controller can tell which device pulled the request line.
  always_comb begin
    poll_view = stb_view;
    poll_view[`SBSR_BIT_MSS] = srq_pend_r;
  end

  // A request is raised only by an enabled event, not by a steady level.
  assign req_evt = |(sum.evt & req_mask); // [RULE3] [RULE6]

  // Pending request: a new event wins over a poll in the same cycle, so
  // the event is not lost when the poll clears the old one.
  // The price is one more poll before the controller sees it go.
  always_comb begin
    srq_pend_nxt = srq_pend_r;
    if (req_evt) begin
      srq_pend_nxt = 1'b1; // [RULE3]
    end else if (do_poll) begin
      srq_pend_nxt = 1'b0;
    end
  end

  // Pending request register; it drives the request line directly.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      srq_pend_r <= 1'b0;
    end else begin
      srq_pend_r <= srq_pend_nxt;
    end
  end

  assign srq_out = srq_pend_r;

  // Mask register, written whole by the set command.
  // Reset clears it, so nothing requests service before a mask is set.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mask_r <= `SBSR_MASK_RST;
    end else if (do_mask_wr) begin
      mask_r <= cmd_data_in; // [RULE4]
    end
  end

  // Answer selection; a mask write has no answer. The query and the poll
  // read the same conditions and differ only in bit 6, so a controller
  // may mix both freely. The mask query returns bit 6 as written even
  // though the request logic never looks at it.
  always_comb begin
    resp_valid_nxt = 1'b0;
    resp_data_nxt  = 8'h00;
    if (cmd_valid_in) begin
      case (cmd_code_in)
        SBSR_CMD_STB_QUERY: begin
          resp_valid_nxt = 1'b1;
          resp_data_nxt  = stb_view;  // [RULE1]
        end
        SBSR_CMD_SERIAL_POLL: begin
          resp_valid_nxt = 1'b1;
          resp_data_nxt  = poll_view; // [RULE1]
        end
        SBSR_CMD_MASK_QUERY: begin
          resp_valid_nxt = 1'b1;
          resp_data_nxt  = mask_r;    // [RULE4]
        end
        default: begin
          resp_valid_nxt = 1'b0;
          resp_data_nxt  = 8'h00;
        end
      endcase
    end
  end

  // Answer registers: one cycle after the command, one cycle wide.
  // Registering costs a cycle but keeps the decoder off the answer path.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
    end else begin
      resp_valid_out <= resp_valid_nxt;
    end
  end

  // Answer data holds until the next answer.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      resp_data_out <= 8'h00;
    end else if (resp_valid_nxt) begin
      resp_data_out <= resp_data_nxt;
    end
  end

  // Mask write followed directly by a mask query.
  sequence s_mask_write;
    cmd_valid_in && cmd_code_in == SBSR_CMD_MASK_WRITE;
  endsequence

  sequence s_mask_query;
    cmd_valid_in && cmd_code_in == SBSR_CMD_MASK_QUERY;
  endsequence

  // A written mask comes back on the next query unchanged.
  a_mask_readback: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_mask_write ##1 s_mask_query |=> resp_valid_out && // [RULE4]
    resp_data_out == $past(cmd_data_in, 2))
    else $error("mask read-back differs");

  // A status query answers next cycle with the status byte.
  a_stb_query: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_valid_in && cmd_code_in == SBSR_CMD_STB_QUERY |=> // [RULE1]
    resp_valid_out && resp_data_out == $past(stb_view))
    else $error("status query answer wrong");

  // A serial poll with no new event reports the pending request and then clears it.
  a_poll_answer: assert property (@(posedge core_clk_in) disable iff (rst_in)
    do_poll && !req_evt |=> resp_valid_out && !srq_out && // [RULE1]
    resp_data_out[`SBSR_BIT_MSS] == $past(srq_pend_r))
    else $error("serial poll answer wrong");

  // An enabled event raises the request line on the next edge.
  a_srq_on_rise: assert property (@(posedge core_clk_in) disable iff (rst_in)
    |(sum.evt & mask_r & `SBSR_REQ_BITS) |=> srq_out) // [RULE3]
    else $error("enabled rise gave no request");

  // Without an enabled event and without a poll the line does not rise.
  a_srq_no_cause: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !srq_out && (sum.evt & mask_r & 8'hbc) == 8'h00 |=> !srq_out) // [RULE2]
    else $error("request raised without cause");

  // The main summary in a query answer matches enabled conditions, bit 6 excluded.
  a_mss_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_valid_in && cmd_code_in == SBSR_CMD_STB_QUERY |=> // [RULE10]
    resp_data_out[`SBSR_BIT_MSS] == $past(|(sum.cond & mask_r & 8'hbc)))
    else $error("main summary wrong");

  // Unused bits read zero in every status answer.
  a_unused_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cmd_valid_in && cmd_code_in != SBSR_CMD_MASK_QUERY &&
    cmd_code_in != SBSR_CMD_MASK_WRITE |=> resp_data_out[1:0] == 2'b00) // [RULE13]
    else $error("unused status bits set");

  // A mask write gives no answer.
  a_write_silent: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_mask_write |=> !resp_valid_out) // [RULE4]
    else $error("mask write answered");

  // The properties below follow the request path one stage at a time,
  // so a failure points at the stage that broke, not the whole chain.
  sequence s_err_armed;
    err_entry_in && req_mask[`SBSR_BIT_ERR] && !do_mask_wr;
  endsequence

  sequence s_srq_kept;
    srq_out && !do_poll;
  endsequence

  sequence s_poll_quiet;
    do_poll && !req_evt;
  endsequence

  // An enabled error entry reaches the request line two edges later.
  a_err_entry_srq: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_err_armed |-> ##2 srq_out) // [RULE6]
    else $error("error entry gave no request");

  // A pending request holds until a serial poll clears it.
  a_srq_holds: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_srq_kept |=> srq_out) // [RULE3]
    else $error("pending request lost");

  // A quiet poll leaves the request line low on the next edge.
  a_poll_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_poll_quiet |=> !srq_out) // [RULE3]
    else $error("poll did not clear request");

  // The request line only rises on an enabled event.
  a_srq_rise_cause: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(srq_out) |-> $past(req_evt)) // [RULE3]
    else $error("request rose without event");

  // A written mask is held whole, bit 6 included, from the next edge on.
  a_mask_stored: assert property (@(posedge core_clk_in) disable iff (rst_in)
    do_mask_wr |=> mask_r == $past(cmd_data_in)) // [RULE4]
    else $error("mask not stored");

  // Without a write the mask keeps its value.
  a_mask_kept: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !do_mask_wr |=> $stable(mask_r)) // [RULE4]
    else $error("mask changed without write");

  // An answer needs a command on the edge before it.
  a_resp_cause: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !cmd_valid_in |=> !resp_valid_out) // [RULE1]
    else $error("answer without command");

  // Answer data stays put between answers, so a slow reader still sees it.
  a_resp_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !resp_valid_out |-> $stable(resp_data_out)) // [RULE1]
    else $error("answer data moved");
endmodule

`default_nettype wire

// ### testbench/sbsr_ctrl_model.sv
/*
  Remote controller model: issues one command per send call, or a mask write and query pair, and captures the answer.
  Assumes the device takes a command on a rising edge and answers one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

module sbsr_ctrl_model (
  input  wire logic                 core_clk_in,
  output var  logic                 cmd_valid_out,
  output var  sbsr_pkg::sbsr_cmd_e  cmd_code_out,
  output var  sbsr_pkg::sbsr_byte_t cmd_data_out,
  input  wire logic                 resp_valid_in,
  input  wire sbsr_pkg::sbsr_byte_t resp_data_in
);
  import sbsr_pkg::*;

  // The bus starts idle so nothing is taken during reset.
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = SBSR_CMD_STB_QUERY;
    cmd_data_out  = 8'h00;
  end

  // One command per call, changed only at falling edges.
  // Data is inverted once released so a stale byte cannot pass for a fresh one.
  task automatic send(input sbsr_cmd_e code, input sbsr_byte_t data,
                      output logic got_v, output sbsr_byte_t got_d);
    @(negedge core_clk_in);
    cmd_valid_out = 1'b1;
    cmd_code_out  = code;
    cmd_data_out  = data;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    cmd_data_out  = ~data;
    got_v         = resp_valid_in;
    got_d         = resp_data_in;
  endtask

  // A mask write and a mask query on two edges in a row.
  task automatic send_wr_rd(input sbsr_byte_t data,
                            output logic got_v, output sbsr_byte_t got_d);
    @(negedge core_clk_in);
    cmd_valid_out = 1'b1;
    cmd_code_out  = SBSR_CMD_MASK_WRITE;
    cmd_data_out  = data;
    @(negedge core_clk_in);
    cmd_code_out  = SBSR_CMD_MASK_QUERY;
    cmd_data_out  = ~data;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    got_v         = resp_valid_in;
    got_d         = resp_data_in;
  endtask
endmodule

`default_nettype wire

// ### testbench/status_byte_service_request_tb.sv
/*
  Self-checking bench for the status byte and service request block.
  Assumes the controller model drives the command port and the bench the status inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module status_byte_service_request_tb;
  import sbsr_pkg::*;

  // One table row: status inputs, mask, expected query answer.
  typedef struct packed {
    logic ne; logic [15:0] qe; logic [15:0] qn; logic mav;
    logic [7:0] es; logic [7:0] ee; logic [15:0] oe; logic [15:0] on;
    sbsr_byte_t msk; sbsr_byte_t exp;
  } sbsr_row_s;

  logic        core_clk_in;  // Core clock.
  logic        rst_in;       // Synchronous reset.
  logic        cmd_valid;    // Command strobe from the model.
  sbsr_cmd_e   cmd_code;     // Command code from the model.
  sbsr_byte_t  cmd_data;     // Command data from the model.
  logic        resp_valid;   // Answer strobe.
  sbsr_byte_t  resp_data;    // Answer byte.
  logic        srq;          // Pending service request.
  logic        err_entry;    // Error entry pulse.
  logic        err_ne;       // Error queue not empty.
  logic        mav;          // Message available.
  logic [15:0] q_ev, q_en, o_ev, o_en;  // Questionable and operation bits.
  logic [7:0]  esr, ese;     // Event status and its enable.
  logic        v;            // Last answer strobe seen.
  sbsr_byte_t  d;            // Last answer byte seen.
  int          fail_count;   // Mismatches.
  int          num_checks;   // Comparisons made.

  // Bits 6 of the masks never count; bits 0 and 1 read zero.
  sbsr_row_s rows [10] = '{
    '{1'b0, 16'h0000, 16'h0000, 1'b0, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'hff, 8'h00},
    '{1'b1, 16'h0000, 16'h0000, 1'b0, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h04, 8'h44},
    '{1'b0, 16'h0010, 16'h0010, 1'b0, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h00, 8'h08},
    '{1'b0, 16'h0010, 16'h0001, 1'b0, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'hff, 8'h00},
    '{1'b0, 16'h0000, 16'h0000, 1'b1, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h10, 8'h50},
    '{1'b0, 16'h0000, 16'h0000, 1'b0, 8'h81, 8'h01, 16'h0000, 16'h0000, 8'h20, 8'h60},
    '{1'b0, 16'h0000, 16'h0000, 1'b0, 8'h80, 8'h01, 16'h0000, 16'h0000, 8'hff, 8'h00},
    '{1'b0, 16'h0000, 16'h0000, 1'b0, 8'h00, 8'h00, 16'h8000, 16'h8000, 8'h7f, 8'h80},
    '{1'b1, 16'h0001, 16'h0001, 1'b1, 8'h01, 8'h01, 16'h0001, 16'h0001, 8'h40, 8'hbc},
    '{1'b1, 16'h0001, 16'h0001, 1'b1, 8'h01, 8'h01, 16'h0001, 16'h0001, 8'h03, 8'hbc}
  };

  // Free-running clock at 4 ns.
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  sbsr_top sbsr_top_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .resp_valid_out(resp_valid),
    .resp_data_out(resp_data), .srq_out(srq), .err_entry_in(err_entry),
    .err_nonempty_in(err_ne), .ques_event_in(q_ev), .ques_enable_in(q_en),
    .msg_avail_in(mav), .esr_in(esr), .ese_in(ese), .oper_event_in(o_ev),
    .oper_enable_in(o_en)
  );

  sbsr_ctrl_model sbsr_ctrl_model_inst (
    .core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
    .cmd_data_out(cmd_data), .resp_valid_in(resp_valid), .resp_data_in(resp_data)
  );

  // Compare tasks, one per result kind.
  task automatic check_byte(input sbsr_byte_t got, input sbsr_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Issue one command through the model.
  task automatic cmd(input sbsr_cmd_e code, input sbsr_byte_t data);
    sbsr_ctrl_model_inst.send(code, data, v, d);
  endtask

  // Apply a row's status inputs at a falling edge.
  task automatic apply(input sbsr_row_s r);
    @(negedge core_clk_in);
    err_ne = r.ne;
    q_ev   = r.qe;
    q_en   = r.qn;
    mav    = r.mav;
    esr    = r.es;
    ese    = r.ee;
    o_ev   = r.oe;
    o_en   = r.on;
  endtask

  // Single ending point for both the tests and the watchdog.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The tests need well under a thousand cycles; this span only catches a hang.
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end

  initial begin
    fail_count = 0;
    num_checks = 0;
    rst_in     = 1'b1;
    err_entry  = 1'b0;
    apply(rows[0]);
    repeat (20) @(negedge core_clk_in);
    check_bit(resp_valid, 1'b0);
    rst_in = 1'b0;
    cmd(SBSR_CMD_MASK_QUERY, 8'h00);
    check_byte(d, 8'h00);
    check_bit(srq, 1'b0);
    $display("test reset done");
    // Table: write mask, read it back whole, then query the status byte.
    foreach (rows[i]) begin
      cmd(SBSR_CMD_MASK_WRITE, rows[i].msk);
      check_bit(v, 1'b0);
      cmd(SBSR_CMD_MASK_QUERY, 8'h00);
      check_byte(d, rows[i].msk);
      apply(rows[i]);
      cmd(SBSR_CMD_STB_QUERY, 8'h00);
      check_byte(d, rows[i].exp);
      check_bit(v, 1'b1);
    end
    $display("test table done");
    // Enabled rise raises a request that stays until a poll.
    apply(rows[0]);
    cmd(SBSR_CMD_MASK_WRITE, 8'h10);
    cmd(SBSR_CMD_SERIAL_POLL, 8'h00);
    mav = 1'b1;
    repeat (3) @(negedge core_clk_in);
    check_bit(srq, 1'b1);
    cmd(SBSR_CMD_SERIAL_POLL, 8'h00);
    check_byte(d, 8'h50);
    check_bit(srq, 1'b0);
    repeat (4) @(negedge core_clk_in);
    check_bit(srq, 1'b0);
    // Mask bit 6 and bits 0 and 1 do not let a rise through.
    mav = 1'b0;
    cmd(SBSR_CMD_MASK_WRITE, 8'h4f);
    mav = 1'b1;
    repeat (3) @(negedge core_clk_in);
    check_bit(srq, 1'b0);
    $display("test request done");
    // Every error entry raises its own request while the queue stays filled.
    err_ne = 1'b1;
    cmd(SBSR_CMD_MASK_WRITE, 8'h04);
    for (int k = 0; k < 2; k++) begin
      cmd(SBSR_CMD_SERIAL_POLL, 8'h00);
      check_bit(srq, 1'b0);
      err_entry = 1'b1;
      @(negedge core_clk_in);
      err_entry = 1'b0;
      repeat (2) @(negedge core_clk_in);
      check_bit(srq, 1'b1);
    end
    $display("test error entries done");
    // A new enabled event bit fires even while the summary is already high.
    cmd(SBSR_CMD_MASK_WRITE, 8'h20);
    ese = 8'h03;
    esr = 8'h01;
    repeat (3) @(negedge core_clk_in);
    cmd(SBSR_CMD_SERIAL_POLL, 8'h00);
    check_bit(srq, 1'b0);
    esr = 8'h03;
    repeat (3) @(negedge core_clk_in);
    check_bit(srq, 1'b1);
    $display("test event status done");
    // A query on the edge right after a write sees the new mask.
    sbsr_ctrl_model_inst.send_wr_rd(8'h5a, v, d);
    check_bit(v, 1'b1);
    check_byte(d, 8'h5a);
    $display("test back to back done");
    complete_run();
  end
endmodule

`default_nettype wire
